// *** include/fsq_pkg.sv ***
// Package for the flash self-program sequencer.
// Assumes a 25 MHz system clock and a 32-bit word bus.
package fsq_pkg;
  // ----------------------------------------
  // Register map, byte addresses
  // ----------------------------------------
  localparam logic [7:0] ADR_CTRL = 8'h00; // Memory control.
  localparam logic [7:0] ADR_KEY = 8'h04; // Unlock key port.
  localparam logic [7:0] ADR_PTR = 8'h08; // Table pointer.
  localparam logic [7:0] ADR_LATCH = 8'h0c; // Table latch.
  localparam logic [7:0] ADR_TWR = 8'h10; // Table write op.
  localparam logic [7:0] ADR_STAT = 8'h14; // Status.
  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int CTL_START = 1; // Start long cycle.
  localparam int CTL_ENABLE = 2; // Program enable.
  localparam int CTL_ERASE = 4; // Erase select.
  localparam int CTL_CFG = 6; // Config space select.
  localparam int ST_BUSY = 0; // Long cycle running.
  localparam int ST_UNLOCK = 1; // Key sequence complete.
  localparam int ST_REFUSED = 2; // Start was refused.
  // ----------------------------------------
  // Values and timing
  // ----------------------------------------
  localparam logic [7:0] KEY_FIRST = 8'h55; // First key.
  localparam logic [7:0] KEY_SECOND = 8'haa; // Second key.
  localparam logic [7:0] HOLD_RESET = 8'hff; // Holding default.
  localparam int HOLD_COUNT = 16; // Holding registers.
  localparam int CLK_MHZ = 25; // System clock rate.
  localparam int LONG_TIME_US = 2000; // Long cycle, about 2 ms.
  localparam int LONG_CYC = LONG_TIME_US * CLK_MHZ; // Cycles.
  // Pointer update modes of a table write op.
  localparam logic [1:0] PM_NONE = 2'h0;
  localparam logic [1:0] PM_POSTINC = 2'h1;
  localparam logic [1:0] PM_POSTDEC = 2'h2;
  localparam logic [1:0] PM_PREINC = 2'h3;
  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [1:0] {FSQ_IDLE, FSQ_ERASE, FSQ_PROG} fsq_mode_t;
  typedef enum logic [1:0] {KEY_NONE, KEY_HALF, KEY_OK} fsq_key_t;
  // Command to the flash array macro.
  typedef struct packed {
    logic erase;
    logic prog;
    logic cfg_sel;
    logic [21:0] addr;
    logic [15:0] mask;
    logic [HOLD_COUNT-1:0][7:0] data;
  } fsq_flash_t;
  // All state of the sequencer except the reset release chain.
  typedef struct packed {
    fsq_mode_t mode;
    fsq_key_t key;
    logic start;
    logic enable;
    logic erase_sel;
    logic cfg_sel;
    logic refused;
    logic [21:0] ptr;
    logic [7:0] latch;
    logic [HOLD_COUNT-1:0][7:0] hold;
    logic [15:0] cnt;
    logic cpu_stall;
    logic waitrequest;
    logic [31:0] readdata;
    fsq_flash_t flash;
  } fsq_state_t;
endpackage : fsq_pkg

// *** rtl/fsq_sequencer.sv ***
// Flash self-program sequencer: holding registers, unlock and long cycles.
// Assumes an Avalon-MM master with waitrequest and a flash macro that
// obeys the erase/prog levels for as long as they are held.
`timescale 1ns/1ps

module fsq_sequencer #(
  parameter int unsigned LONG_CYCLES = fsq_pkg::LONG_CYC
) (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic nrst,
  // Avalon-MM slave.
  input wire logic [7:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [3:0] byteenable,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  // CPU halt and flash macro command.
  output logic cpu_stall,
  output fsq_pkg::fsq_flash_t flash
);
  import fsq_pkg::*;

  // ----------------------------------------
  // Reset release
  // ----------------------------------------
  logic [1:0] rst_sync; // Two-stage release chain.
  logic rst_n; // Synchronised reset, active low.

  // Assert at once, release after two clean edges.
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      rst_sync <= 2'h0;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_n = rst_sync[1];

  // ----------------------------------------
  // State
  // ----------------------------------------
  fsq_state_t q; // Registered state.
  fsq_state_t next_q; // Next state.
  logic take_wr; // Write accepted at this edge.
  logic take_rd; // Read accepted at this edge.
  logic [21:0] ptr_wr; // Pointer as written by the bus.
  logic [3:0] hold_idx; // Holding register addressed.
  logic go; // A start attempt is being made.
  logic go_ok; // The attempt is accepted.
  logic [15:0] ff_mask; // Bytes that really get programmed.

  // A request is taken on the edge where waitrequest is seen low.
  assign take_wr = write && !q.waitrequest;
  assign take_rd = read && !q.waitrequest;

  // Bytes still at the erased value are masked off so that a
  // partly loaded buffer programs only what was loaded.
  always_comb begin
    for (int i = 0; i < HOLD_COUNT; i++) begin
      ff_mask[i] = (q.hold[i] != HOLD_RESET);
    end
  end

  // ----------------------------------------
  // Next-state logic
  // ----------------------------------------
  always_comb begin
    next_q = q;
    next_q.waitrequest = 1'b1;
    ptr_wr = q.ptr;
    hold_idx = q.ptr[3:0];
    go = 1'b0;
    go_ok = 1'b0;

    // Long cycle: only the counter ends it, never the bus.
    if (q.mode != FSQ_IDLE) begin
      if (q.cnt == 16'h0) begin
        next_q.mode = FSQ_IDLE;
        next_q.start = 1'b0;
        next_q.cpu_stall = 1'b0;
        next_q.flash.erase = 1'b0;
        next_q.flash.prog = 1'b0;
        if (q.mode == FSQ_PROG) begin
          // Buffer is spent; back to the neutral value.
          for (int i = 0; i < HOLD_COUNT; i++) begin
            next_q.hold[i] = HOLD_RESET;
          end
        end
      end else begin
        next_q.cnt = q.cnt - 16'h1;
      end
    end

    // Answer a pending request one cycle after it appears.
    // While a long cycle runs the bus is held off, which is
    // how the CPU sees the halt.
    if ((read || write) && q.waitrequest && q.mode == FSQ_IDLE) begin
      next_q.waitrequest = 1'b0;
      unique case (address)
        ADR_CTRL: begin
          next_q.readdata = 32'h0;
          next_q.readdata[CTL_START] = q.start;
          next_q.readdata[CTL_ENABLE] = q.enable;
          next_q.readdata[CTL_ERASE] = q.erase_sel;
          next_q.readdata[CTL_CFG] = q.cfg_sel;
        end
        ADR_PTR: begin
          next_q.readdata = {10'h0, q.ptr};
        end
        ADR_LATCH: begin
          next_q.readdata = {24'h0, q.latch};
        end
        ADR_STAT: begin
          next_q.readdata = 32'h0;
          next_q.readdata[ST_BUSY] = (q.mode != FSQ_IDLE);
          next_q.readdata[ST_UNLOCK] = (q.key == KEY_OK);
          next_q.readdata[ST_REFUSED] = q.refused;
        end
        default: begin
          // Key port and table write op read as zero, as does
          // every unmapped address.
          next_q.readdata = 32'h0;
        end
      endcase
    end

    // Any access to the key port other than the right pair
    // breaks the sequence.
    if (take_rd && address == ADR_KEY) begin
      next_q.key = KEY_NONE;
    end

    if (take_wr) begin
      unique case (address)
        ADR_CTRL: begin
          if (byteenable[0]) begin
            next_q.enable = writedata[CTL_ENABLE];
            next_q.erase_sel = writedata[CTL_ERASE];
            next_q.cfg_sel = writedata[CTL_CFG];
            // Writing zero to start does nothing.
            go = writedata[CTL_START] && !q.start;
          end
        end
        ADR_KEY: begin
          if (byteenable[0] && writedata[7:0] == KEY_FIRST) begin
            next_q.key = KEY_HALF;
          end else if (byteenable[0] && writedata[7:0] == KEY_SECOND
                       && q.key == KEY_HALF) begin
            next_q.key = KEY_OK;
          end else begin
            next_q.key = KEY_NONE;
          end
        end
        ADR_PTR: begin
          if (byteenable[0]) begin
            ptr_wr[7:0] = writedata[7:0];
          end
          if (byteenable[1]) begin
            ptr_wr[15:8] = writedata[15:8];
          end
          if (byteenable[2]) begin
            ptr_wr[21:16] = writedata[21:16];
          end
          next_q.ptr = ptr_wr;
        end
        ADR_LATCH: begin
          if (byteenable[0]) begin
            next_q.latch = writedata[7:0];
          end
        end
        ADR_TWR: begin
          // Short write: holding register and pointer only, no stall.
          if (writedata[1:0] == PM_PREINC) begin
            next_q.ptr[20:0] = q.ptr[20:0] + 21'h1;
          end
          hold_idx = next_q.ptr[3:0];
          next_q.hold[hold_idx] = q.latch;
          if (writedata[1:0] == PM_POSTINC) begin
            next_q.ptr[20:0] = q.ptr[20:0] + 21'h1;
          end else if (writedata[1:0] == PM_POSTDEC) begin
            next_q.ptr[20:0] = q.ptr[20:0] - 21'h1;
          end
        end
        ADR_STAT: begin
          // Write one to clear the refused flag.
          if (byteenable[0] && writedata[ST_REFUSED]) begin
            next_q.refused = 1'b0;
          end
        end
        default: begin
          // Unmapped writes are answered and dropped.
          next_q.refused = q.refused;
        end
      endcase
    end

    // Every attempt uses up the unlock, so a stray second start
    // needs a fresh key pair.
    if (go) begin
      next_q.key = KEY_NONE;
      go_ok = next_q.enable && q.key == KEY_OK;
      if (go_ok) begin
        next_q.start = 1'b1;
        next_q.cpu_stall = 1'b1;
        next_q.cnt = 16'(LONG_CYCLES - 1);
        next_q.flash.cfg_sel = next_q.cfg_sel;
        if (next_q.erase_sel) begin
          // Whole 64-byte block; low six bits dropped.
          next_q.mode = FSQ_ERASE;
          next_q.flash.erase = 1'b1;
          next_q.flash.addr = {q.ptr[21:6], 6'h0};
          next_q.flash.mask = 16'h0;
        end else begin
          // Sixteen bytes at once from the holding registers.
          next_q.mode = FSQ_PROG;
          next_q.flash.prog = 1'b1;
          next_q.flash.addr = {q.ptr[21:4], 4'h0};
          next_q.flash.data = q.hold;
          next_q.flash.mask = ff_mask;
        end
      end else begin
        // Refused starts set a flag; the set beats a clear.
        next_q.refused = 1'b1;
      end
    end
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
      q.mode <= FSQ_IDLE;
      q.key <= KEY_NONE;
      q.waitrequest <= 1'b1;
      q.hold <= {HOLD_COUNT{HOLD_RESET}};
    end else begin
      q <= next_q;
    end
  end

  // Outputs come straight from the state register.
  assign readdata = q.readdata;
  assign waitrequest = q.waitrequest;
  assign cpu_stall = q.cpu_stall;
  assign flash = q.flash;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  int unsigned stall_len; // Cycles the stall has been high.
  logic [15:0] exp_mask; // Mask recomputed from the data.

  // Counts the width of each stall pulse.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      stall_len <= 0;
    end else begin
      stall_len <= q.cpu_stall ? stall_len + 1 : 0;
    end
  end

  // Which bytes the command data says should be written.
  always_comb begin
    for (int i = 0; i < HOLD_COUNT; i++) begin
      exp_mask[i] = (q.flash.data[i] != HOLD_RESET);
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  // The bus is held off during a cycle, so the pointer still names the target.
  a_erase_block_align: assert property (q.flash.erase |-> q.flash.addr[5:0] == 6'h0
      && q.flash.addr[21:6] == q.ptr[21:6])
    else $error("Erase address not block aligned.");
  a_prog_row_align: assert property (q.flash.prog |-> q.flash.addr[3:0] == 4'h0
      && q.flash.addr[21:4] == q.ptr[21:4])
    else $error("Program address not 16-byte aligned.");
  a_start_needs_enable: assert property ($rose(q.cpu_stall) |-> q.enable)
    else $error("Long cycle began with writes disabled.");
  a_start_needs_keys: assert property ($rose(q.cpu_stall) |-> $past(q.key) == KEY_OK)
    else $error("Long cycle began without unlock.");
  a_erase_follows_sel: assert property ($rose(q.cpu_stall) |-> q.flash.erase == q.erase_sel)
    else $error("Cycle kind does not match erase select.");
  a_stall_holds_bus: assert property (q.cpu_stall |-> q.waitrequest && !waitrequest == 1'b0)
    else $error("Bus answered during a long cycle.");
  a_cycle_length: assert property ($fell(q.cpu_stall) |-> stall_len == LONG_CYCLES)
    else $error("Long cycle length wrong.");
  a_start_self_clear: assert property ($fell(q.cpu_stall) |-> !q.start && q.mode == FSQ_IDLE)
    else $error("Start bit not cleared at cycle end.");
  a_hold_refill: assert property ($fell(q.flash.prog) |-> q.hold == {HOLD_COUNT{HOLD_RESET}})
    else $error("Holding registers not reset after program.");
  a_skip_ff_bytes: assert property (q.flash.prog |-> q.flash.mask == exp_mask)
    else $error("Byte mask disagrees with holding data.");
  a_twr_no_stall: assert property (take_wr && address == ADR_TWR |=> !q.cpu_stall ##1 !q.cpu_stall)
    else $error("Table write stalled the CPU.");
  a_twr_target: assert property (take_wr && address == ADR_TWR
      && writedata[1:0] == PM_NONE |=> q.hold[$past(q.ptr[3:0])] == $past(q.latch))
    else $error("Table write hit the wrong holding register.");

  // A start attempt without a fresh key pair must not open a cycle.
  // It reads the decoder state q.key, so a key decoder that forgets to reset goes unseen.
  a_locked_no_cycle: assert property (take_wr && address == ADR_CTRL
      && writedata[CTL_START] && q.key != KEY_OK |=> !q.cpu_stall)
    else $error("Start taken without a fresh unlock.");
  // The enable bit of the same write decides, not an older copy.
  a_disabled_no_cycle: assert property (take_wr && address == ADR_CTRL
      && writedata[CTL_START] && !writedata[CTL_ENABLE] |=> !q.cpu_stall)
    else $error("Start taken with writes disabled.");
  // An accepted start stalls the core and shows the start bit at once.
  a_accept_stalls: assert property (go_ok |=> q.cpu_stall && q.start)
    else $error("Accepted start did not begin a long cycle.");

  c_erase_cycle: cover property ($rose(q.flash.erase) ##[1:1000] q.cpu_stall);
  c_prog_cycle: cover property ($fell(q.flash.prog));
  c_refused_start: cover property ($rose(q.refused));
  // A partly loaded buffer is the case that the byte mask exists for.
  c_partial_prog: cover property ($rose(q.flash.prog) && q.flash.mask != 16'hffff);
endmodule : fsq_sequencer

// *** tb/fsq_cpu_model.sv ***
// CPU core model: Avalon-MM master that issues register and table writes.
// Assumes a slave that answers by dropping waitrequest for one cycle.
`timescale 1ns/1ps
module fsq_cpu_model (
  // Clock and slave answer.
  input wire logic ref_clk,
  input wire logic waitrequest,
  // Avalon-MM request.
  output logic [7:0] address,
  output logic read,
  output logic write,
  output logic [3:0] byteenable,
  output logic [31:0] writedata
);
  // --------------------------------------------------------------
  // Bus cycles
  // --------------------------------------------------------------
  // Idle bus at time zero; all lanes always enabled.
  initial begin
    address = 8'h00;
    read = 1'b0;
    write = 1'b0;
    byteenable = 4'hf;
    writedata = 32'h0;
  end

  // One access, held until waitrequest is sampled low. The core assumes no
  // answer time: a long cycle may hold it off, and only the watchdog ends a hang.
  task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
    address <= a;
    writedata <= d;
    write <= w;
    read <= !w;
    @(posedge ref_clk);
    while (waitrequest !== 1'b0) begin
      @(posedge ref_clk);
    end
    read <= 1'b0;
    write <= 1'b0;
    writedata <= ~d;
    // A slow core: one or two idle cycles before the next access.
    repeat (1 + $urandom % 2) @(posedge ref_clk);
  endtask : acc

  // Key pair written back to back, nothing else touching the key port.
  task automatic unlock();
    acc(1'b1, fsq_pkg::ADR_KEY, {24'h0, fsq_pkg::KEY_FIRST});
    acc(1'b1, fsq_pkg::ADR_KEY, {24'h0, fsq_pkg::KEY_SECOND});
  endtask : unlock
endmodule : fsq_cpu_model

// *** tb/tb_flash_self_program_sequencer.sv ***
// Self-checking bench for the flash self-program sequencer.
// Assumes the design package and a shortened long cycle of LC clocks.
`timescale 1ns/1ps
module tb_flash_self_program_sequencer;
  import fsq_pkg::*;
  localparam int LC = 20; // Shortened long cycle keeps the run brief.
  logic ref_clk;
  logic nrst;
  logic [7:0] address;
  logic read;
  logic write;
  logic [3:0] byteenable;
  logic [31:0] writedata;
  logic [31:0] readdata;
  logic waitrequest;
  logic cpu_stall;
  fsq_flash_t flash;
  int failures = 0;
  int n_compared = 0;
  logic [63:0] exp_rd[$]; // Mask and value of each expected read.
  fsq_flash_t exp_fl[$]; // Expected command of each long cycle.
  logic [7:0] hold [16]; // Reference copy of the holding registers.
  logic [21:0] ptr;
  logic [21:0] base;
  logic [1:0] pm;
  logic [7:0] lat;
  logic stall_q = 1'b0;
  int cnt = 0;
  localparam logic [31:0] EN = 32'h1 << CTL_ENABLE;
  localparam logic [31:0] ST = 32'h1 << CTL_START;

  fsq_sequencer #(.LONG_CYCLES(LC)) dut_u (.ref_clk(ref_clk), .nrst(nrst),
    .address(address), .read(read), .write(write), .byteenable(byteenable),
    .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
    .cpu_stall(cpu_stall), .flash(flash));
  fsq_cpu_model cpu_u (.ref_clk(ref_clk), .waitrequest(waitrequest), .address(address),
    .read(read), .write(write), .byteenable(byteenable), .writedata(writedata));

  // --------------------------------------------------------------
  // Clock, watchdog and helpers
  // --------------------------------------------------------------
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  // The tests need about 80 accesses; far beyond that means a hang.
  initial begin
    repeat (20000) @(posedge ref_clk);
    failures++;
    final_report();
  end

  task automatic final_report();
    $display("compared %0d, failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : final_report

  task automatic chk(input logic ok, input string msg);
    n_compared++;
    if (ok !== 1'b1) begin
      failures++;
      $display("Error at %0t: %s", $time, msg);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    cpu_u.acc(1'b1, a, d);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] v);
    exp_rd.push_back({m, v});
    cpu_u.acc(1'b0, a, 32'h0);
  endtask : rd

  // Unlocked long cycle; erase select chooses erase or program.
  task automatic long_cycle(input logic ers);
    fsq_flash_t x;
    x = '0;
    x.erase = ers;
    x.prog = !ers;
    x.addr = ers ? {ptr[21:6], 6'h0} : {ptr[21:4], 4'h0};
    for (int i = 0; i < 16; i++) begin
      x.data[i] = hold[i];
      x.mask[i] = (hold[i] !== 8'hff);
    end
    wr(ADR_CTRL, EN | (32'(ers) << CTL_ERASE));
    cpu_u.unlock();
    rd(ADR_STAT, 32'h2, 32'h2);
    exp_fl.push_back(x);
    wr(ADR_CTRL, EN | ST | (32'(ers) << CTL_ERASE));
    rd(ADR_CTRL, ST, 32'h0);
    if (!ers) begin
      foreach (hold[i]) hold[i] = 8'hff;
    end
  endtask : long_cycle

  // --------------------------------------------------------------
  // Output monitor: takes the oldest note whenever a result appears
  // --------------------------------------------------------------
  always @(posedge ref_clk) begin : monitor
    fsq_flash_t f;
    logic [63:0] r;
    if (read === 1'b1 && waitrequest === 1'b0) begin
      chk(exp_rd.size() > 0, "read without expectation");
      r = exp_rd.pop_front();
      chk((readdata & r[63:32]) === r[31:0], "read data");
    end
    if (cpu_stall === 1'b1 && stall_q !== 1'b1) begin
      chk(exp_fl.size() > 0, "unexpected long cycle");
      f = exp_fl.pop_front();
      cnt = 1;
      if (f.erase) begin
        chk({flash.erase, flash.prog, flash.addr} === {2'b10, f.addr}, "erase cmd");
      end else begin
        chk(flash === f, "program cmd");
      end
    end else if (cpu_stall === 1'b1) begin
      cnt++;
      chk((flash.erase | flash.prog) === 1'b1, "cycle dropped");
    end else if (stall_q === 1'b1) begin
      chk(cnt === LC, "stall length");
    end
    stall_q = cpu_stall;
  end

  // --------------------------------------------------------------
  // Tests
  // --------------------------------------------------------------
  initial begin
    nrst = 1'b0;
    foreach (hold[i]) hold[i] = 8'hff;
    void'($urandom(32'h4b69));
    repeat (12) @(posedge ref_clk);
    nrst <= 1'b1;
    repeat (3) @(posedge ref_clk);
    rd(ADR_STAT, 32'h7, 32'h0);
    wr(8'h20, 32'hffffffff);
    rd(ADR_CTRL, 32'hff, 32'h0);
    rd(8'h20, 32'hffffffff, 32'h0);
    $display("test reset done");
    ptr = {1'b0, 21'($urandom)};
    wr(ADR_PTR, {10'h0, ptr});
    long_cycle(1'b1);
    $display("test erase done");
    base = {1'b0, 17'($urandom), 4'h0};
    ptr = base;
    wr(ADR_PTR, {10'h0, ptr});
    for (int k = 0; k < 8; k++) begin
      pm = 2'($urandom);
      lat = (k == 2) ? 8'hff : 8'($urandom);
      wr(ADR_LATCH, {24'h0, lat});
      if (pm == PM_PREINC) ptr[20:0] = ptr[20:0] + 21'h1;
      hold[ptr[3:0]] = lat;
      wr(ADR_TWR, {30'h0, pm});
      if (pm == PM_POSTINC) ptr[20:0] = ptr[20:0] + 21'h1;
      if (pm == PM_POSTDEC) ptr[20:0] = ptr[20:0] - 21'h1;
    end
    rd(ADR_PTR, 32'h3fffff, {10'h0, ptr});
    rd(ADR_LATCH, 32'hff, {24'h0, lat});
    ptr = {base[21:4], 4'($urandom)};
    wr(ADR_PTR, {10'h0, ptr});
    long_cycle(1'b0);
    long_cycle(1'b0);
    $display("test program done");
    // A reset in mid-run must throw away a loaded holding byte.
    wr(ADR_LATCH, 32'h5a);
    wr(ADR_TWR, 32'h0);
    nrst <= 1'b0;
    repeat (2) @(posedge ref_clk);
    nrst <= 1'b1;
    repeat (3) @(posedge ref_clk);
    ptr = 22'h0;
    rd(ADR_PTR, 32'h3fffff, 32'h0);
    long_cycle(1'b0);
    $display("test reset refill done");
    for (int c = 0; c < 4; c++) begin
      wr(ADR_CTRL, (c == 0) ? 32'h0 : EN);
      if (c != 1) wr(ADR_KEY, {24'h0, (c == 3) ? KEY_SECOND : KEY_FIRST});
      if (c == 2) rd(ADR_KEY, 32'hff, 32'h0);
      if (c != 1) wr(ADR_KEY, {24'h0, (c == 3) ? KEY_FIRST : KEY_SECOND});
      wr(ADR_CTRL, ((c == 0) ? 32'h0 : EN) | ST);
      rd(ADR_STAT, 32'h7, 32'h1 << ST_REFUSED);
      wr(ADR_STAT, 32'h1 << ST_REFUSED);
      rd(ADR_STAT, 32'h7, 32'h0);
    end
    $display("test refusal done");
    repeat (4) @(posedge ref_clk);
    chk(exp_rd.size() == 0 && exp_fl.size() == 0, "results missing");
    final_report();
  end
endmodule : tb_flash_self_program_sequencer
